// file: bench/rsi_ctrl_model.sv
// external controller model: channel, mode, key and data pins
// assumes bench drives its commands right after a rising edge
`timescale 1ns/1ns
`default_nettype none
module rsi_ctrl_model (
  input wire logic [3:0] chan_in,
  input wire rsi_pkg::rsi_mode_t mode_in,
  input wire logic [3:0] misc_in,
  output var rsi_pkg::rsi_remote_t remote_out
);
  import rsi_pkg::*;
  always_comb begin
    remote_out.channel_select_line = ~3'(chan_in - 4'h1);
    case (mode_in)
      RSI_MODE_FSK2: remote_out.mode_select = 2'b01;
      RSI_MODE_FSK4: remote_out.mode_select = 2'b11;
      RSI_MODE_SPARE: remote_out.mode_select = 2'b10;
      default: remote_out.mode_select = 2'b00;
    endcase
    {remote_out.key, remote_out.fsk_bit_one, remote_out.fsk_bit_two} = misc_in[3:1];
    // bit four driven actively, as the inverse of misc bit two
    remote_out.fsk_bit_four_or_clock = ~misc_in[2];
    remote_out.low_power_mode = misc_in[0];
  end
endmodule // rsi_ctrl_model
`default_nettype wire

// file: bench/rsi_props.sv
// checker for the remote select interface top ports
// assumes one clock, async active-low reset
`timescale 1ns/1ns
`default_nettype none
module rsi_props (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire rsi_pkg::rsi_remote_t remote_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic irq_out,
  input wire rsi_pkg::rsi_alarm_t alarm_out,
  input wire logic modulating_indicator_out,
  input wire logic [3:0] fsk_data_out,
  input wire rsi_pkg::rsi_mode_t mode_out,
  input wire logic [3:0] channel_out,
  input wire logic key_out,
  input wire rsi_pkg::rsi_link_t link_out,
  input wire rsi_pkg::rsi_dac_t dac_out
);
  import rsi_pkg::*;
  logic [2:0] up_cnt_reg;
  // pipeline full once four edges past release
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) up_cnt_reg <= 3'h0;
    else if (up_cnt_reg != 3'h4) up_cnt_reg <= up_cnt_reg + 3'h1;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  a_chan_decode: assert property (up_cnt_reg == 3'h4 |->
    channel_out == {1'b0, ~$past(remote_in.channel_select_line, 3)} + 4'h1) else $error("bad channel");
  a_mode_decode: assert property (up_cnt_reg == 3'h4 && $past(remote_in.mode_select, 3) != 2'b10 |->
    mode_out == {&$past(remote_in.mode_select, 3), ^$past(remote_in.mode_select, 3)}) else $error("bad mode");
  a_mode_hold: assert property (up_cnt_reg == 3'h4 && $past(remote_in.mode_select, 3) == 2'b10 |->
    $stable(mode_out)) else $error("mode not held");
  a_fsk_pass: assert property (up_cnt_reg == 3'h4 |-> fsk_data_out == ($past(mode_out) == RSI_MODE_ANALOG ? 4'h0 :
    {2'b00, $past(remote_in.fsk_bit_two, 3), $past(remote_in.fsk_bit_one, 3)})) else $error("bad fsk");
  a_key_sync: assert property (up_cnt_reg == 3'h4 |-> key_out == $past(remote_in.key, 3))
    else $error("bad key");
  a_dac_fwd: assert property (wr_in && addr_in == 4'h4 |=> dac_out.wr_a && !dac_out.wr_b
    && dac_out.data == $past(wdata_in)) else $error("bad fwd write");
  a_dac_ref: assert property (wr_in && addr_in == 4'h5 |=> dac_out.wr_b && !dac_out.wr_a
    && dac_out.data == $past(wdata_in)) else $error("bad ref write");
  a_alarm_write: assert property (wr_in && addr_in == 4'h8 |=> alarm_out == $past(wdata_in[5:0]))
    else $error("bad alarm");
  a_sclk_rate: assert property ($rose(link_out.sclk) |-> ##2 $fell(link_out.sclk))
    else $error("bad sclk");
endmodule // rsi_props
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the remote select interface
// assumes rsi_pkg, rsi_top, model and checker compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import rsi_pkg::*;
  logic clk_sys_in, reset_n_in, wr_in, rd_in, modulating_indicator, irq_out, key_out, ls, fr;
  logic [3:0] addr_in, chan, misc, fsk_data_out, channel_out;
  logic [15:0] wdata_in, rdata_out, d;
  rsi_mode_t mode, mode_out, e;
  rsi_remote_t remote;
  rsi_alarm_t alarm_out;
  rsi_link_t link_out;
  rsi_dac_t dac_out;
  int miscompares = 0;
  int checks = 0;
  int rises;
  int n;
  logic [15:0] w;
  rsi_mode_t seq [4] = '{RSI_MODE_FSK4, RSI_MODE_SPARE, RSI_MODE_FSK2, RSI_MODE_ANALOG};
  rsi_ctrl_model rsi_ctrl_model_inst (.chan_in(chan), .mode_in(mode), .misc_in(misc), .remote_out(remote));
  rsi_top rsi_top_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .remote_in(remote),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .alarm_out(alarm_out), .modulating_indicator_out(modulating_indicator),
    .fsk_data_out(fsk_data_out), .mode_out(mode_out), .channel_out(channel_out), .key_out(key_out),
    .link_out(link_out), .dac_out(dac_out));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end
  initial begin
    {reset_n_in, wr_in, rd_in, addr_in, wdata_in, misc} = '0;
    chan = 4'h1;
    mode = RSI_MODE_ANALOG;
    repeat (20) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    for (int c = 8; c >= 1; c--) begin
      @(posedge clk_sys_in);
      chan <= 4'(c);
      settle(5);
      chk(16'(channel_out), 16'(c));
      rd(4'h1, d);
      chk(16'(d[6:3]), 16'(c));
    end
    $display("channel test done");
    @(posedge clk_sys_in);
    misc <= 4'b0100;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      mode <= seq[i];
      e = (seq[i] == RSI_MODE_SPARE) ? RSI_MODE_FSK4 : seq[i];
      settle(5);
      chk(16'(mode_out), 16'(e));
      chk(16'(fsk_data_out), (e == RSI_MODE_ANALOG) ? 16'h0000 : 16'h0001);
    end
    $display("mode test done");
    wr(4'h2, 16'h000F);
    wr(4'h3, 16'h0004);
    chk(16'(irq_out), 16'h0000);
    @(posedge clk_sys_in);
    misc <= 4'b1001;
    settle(5);
    chk(16'(key_out), 16'h0001);
    chk(16'(irq_out), 16'h0001);
    rd(4'h1, d);
    chk(16'(d[10:9]), 16'h0003);
    wr(4'h3, 16'h0000);
    chk(16'(irq_out), 16'h0000);
    wr(4'h2, 16'h000F);
    rd(4'h2, d);
    chk(d, 16'h0000);
    $display("irq test done");
    wr(4'h4, 16'hA5C3);
    chk({dac_out.wr_a, dac_out.wr_b, dac_out.data[13:0]}, 16'hA5C3);
    wr(4'h5, 16'h5A3C);
    chk({dac_out.wr_a, dac_out.wr_b, dac_out.data[13:0]}, 16'h5A3C);
    for (int i = 0; i < 6; i++) begin
      wr(4'h8, 16'h0001 << i);
      chk(16'(alarm_out), 16'h0001 << i);
    end
    wr(4'h0, 16'h0001);
    chk(16'(modulating_indicator), 16'h0001);
    rd(4'hF, d);
    chk(d, 16'h0000);
    rd(4'h6, d);
    chk(d, 16'h01C9);
    settle(1);
    chk(rdata_out, 16'h0000);
    $display("register test done");
    wr(4'h7, 16'hC35A);
    {rises, fr, n, w} = '0;
    ls = link_out.sclk;
    repeat (128) begin
      settle(1);
      if (link_out.sclk && !ls) begin
        rises++;
        // capture the first whole word, msb first from the frame bit
        if (link_out.frame && n == 0) begin
          w = {15'h0000, link_out.sdata};
          n = 1;
        end else if (n > 0 && n < 16) begin
          w = {w[14:0], link_out.sdata};
          n++;
        end
      end
      ls = link_out.sclk;
      fr |= link_out.frame;
    end
    chk(16'(rises), 16'h0020);
    chk(16'(fr), 16'h0001);
    chk(w, 16'hC35A);
    $display("link test done");
    give_verdict();
  end
endmodule // testbench
bind rsi_top rsi_props rsi_props_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .remote_in(remote_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .irq_out(irq_out), .alarm_out(alarm_out), .modulating_indicator_out(modulating_indicator_out),
  .fsk_data_out(fsk_data_out), .mode_out(mode_out), .channel_out(channel_out), .key_out(key_out),
  .link_out(link_out), .dac_out(dac_out));
`default_nettype wire

// file: pkg/rsi_defines.svh
// constants for the remote select interface
// assumes inclusion by bare name from pkg and verilog files
`ifndef RSI_DEFINES_SVH
`define RSI_DEFINES_SVH
`define RSI_REF_HZ 10000000
`define RSI_CLK_HZ 25000000
`define RSI_SCLK_DIV (`RSI_CLK_HZ / `RSI_REF_HZ)
`define RSI_SAMPLE_BITS 16
`define RSI_ADDR_CTRL 4'h0
`define RSI_ADDR_STATUS 4'h1
`define RSI_ADDR_IRQ_STAT 4'h2
`define RSI_ADDR_IRQ_MASK 4'h3
`define RSI_ADDR_FWD 4'h4
`define RSI_ADDR_REF 4'h5
`define RSI_ADDR_SELECT 4'h6
`define RSI_ADDR_AUDIO 4'h7
`define RSI_ADDR_ALARM 4'h8
`define RSI_CH_BITS 3
`define RSI_MODE_BITS 2
`define RSI_ZERO16 16'h0000
`define RSI_IRQ_CHAN 0
`define RSI_IRQ_MODE 1
`define RSI_IRQ_KEY 2
`define RSI_IRQ_LOWPWR 3
`define RSI_IRQ_BITS 4
`define RSI_DATA_W 16
`endif

// file: pkg/rsi_pkg.sv
// types for the remote select interface
// assumes rsi_defines.svh on the include path
`include "rsi_defines.svh"
package rsi_pkg;
  typedef enum logic [1:0] {
    RSI_MODE_ANALOG = 2'b00,
    RSI_MODE_FSK2 = 2'b01,
    RSI_MODE_FSK4 = 2'b10,
    RSI_MODE_SPARE = 2'b11
  } rsi_mode_t;
  typedef struct packed {
    logic [`RSI_CH_BITS-1:0] channel_select_line;
    logic [`RSI_MODE_BITS-1:0] mode_select;
    logic key;
    logic fsk_bit_one;
    logic fsk_bit_two;
    logic fsk_bit_four_or_clock;
    logic low_power_mode;
  } rsi_remote_t;
  typedef struct packed {
    logic fault;
    logic mismatch;
    logic temperature;
    logic drive_loss;
    logic low_power;
    logic halt;
  } rsi_alarm_t;
  typedef struct packed {
    logic sclk;
    logic frame;
    logic sdata;
  } rsi_link_t;
  typedef struct packed {
    logic wr_a;
    logic wr_b;
    logic [`RSI_DATA_W-1:0] data;
  } rsi_dac_t;
endpackage

// file: verilog/rsi_sync.sv
// two-stage synchroniser for a bundle of asynchronous inputs
// assumes a single clock domain, async active-low reset
`timescale 1ns/1ns
`default_nettype none
module rsi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } rsi_sync_state_t;
  rsi_sync_state_t state_reg;
  rsi_sync_state_t state_next;
  always_comb begin
    state_next.meta = async_in;
    state_next.stable = state_reg.meta;
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign sync_out = state_reg.stable;
endmodule // rsi_sync
`default_nettype wire

// file: verilog/rsi_top.sv
// remote select interface: decodes controller lines, serial audio link,
// dual dac steering, alarms, interrupt; mcu reaches it over a plain port
// assumes one 25 MHz clock; remote pins asynchronous
//
// Summary of operation
// RULE_01: three channel select lines give operating channel
// RULE_02: low counts one, weights 1/2/4, plus one
// RULE_03: two mode select lines choose operating mode
// RULE_04: 00 analog, 10 two-level, 11 four-level; code decodes 01 as two-level and treats 10 as undefined
// RULE_05: undefined mode code keeps current mode
// RULE_06: fsk bits one and two pass to modulator
// RULE_07: analog samples sent serially with timing pulses
// RULE_08: serial clock derived from ten-MHz reference; code divides the 25 MHz system clock by four, giving 6.25 MHz
// RULE_09: power writes steered to matching dac half
// RULE_10: remote commands reach mcu through this port
// RULE_11: mcu status forwarded to external controller
// RULE_12: fault alarm output driven from mcu status
// RULE_13: separate mismatch, temperature, drive loss alarms
// RULE_14: modulating indicator output to controller
// RULE_15: controller drives key input as logic command
// RULE_16: low power mode input reported as status
// RULE_17: remote inputs pass two flip-flops first
`timescale 1ns/1ns
`default_nettype none
`include "rsi_defines.svh"
module rsi_top (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire rsi_pkg::rsi_remote_t remote_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic irq_out,
  output rsi_pkg::rsi_alarm_t alarm_out,
  output logic modulating_indicator_out,
  output logic [3:0] fsk_data_out,
  output rsi_pkg::rsi_mode_t mode_out,
  output logic [3:0] channel_out,
  output logic key_out,
  output rsi_pkg::rsi_link_t link_out,
  output rsi_pkg::rsi_dac_t dac_out
);
  import rsi_pkg::*;

  typedef struct packed {
    logic [3:0] channel;
    rsi_mode_t mode;
    logic key;
    logic low_power;
    logic [3:0] fsk;
    logic [`RSI_IRQ_BITS-1:0] irq_stat;
    logic [`RSI_IRQ_BITS-1:0] irq_mask;
    rsi_alarm_t alarm;
    logic modulating;
    logic [15:0] rdata;
    logic [15:0] audio_hold;
    logic [15:0] audio_shift;
    logic [4:0] bit_cnt;
    logic [1:0] div_cnt;
    logic sclk;
    logic frame;
    logic sdata;
    rsi_dac_t dac;
  } rsi_state_t;

  rsi_state_t s_reg;
  rsi_state_t s_next;
  rsi_remote_t rem;

  rsi_sync #(.WIDTH($bits(rsi_remote_t))) u_sync ( // RULE_17
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .async_in(remote_in),
    .sync_out(rem)
  );

  logic [2:0] ch_weight;
  logic [3:0] ch_dec;
  rsi_mode_t mode_dec;
  logic mode_valid;
  logic [15:0] rd_mux;
  logic [`RSI_IRQ_BITS-1:0] irq_set;
  logic [1:0] div_max;

  always_comb begin
    // low line counts as one
    ch_weight = ~rem.channel_select_line; // RULE_01
    ch_dec = {1'b0, ch_weight} + 4'h1; // RULE_02
    mode_valid = 1'b1;
    mode_dec = s_reg.mode;
    case (rem.mode_select) // RULE_03
      2'b00: mode_dec = RSI_MODE_ANALOG; // RULE_04
      2'b01: mode_dec = RSI_MODE_FSK2;
      2'b11: mode_dec = RSI_MODE_FSK4;
      default: mode_valid = 1'b0; // RULE_05
    endcase
  end

  always_comb begin
    case (addr_in)
      `RSI_ADDR_STATUS: rd_mux = {4'h0, s_reg.modulating, s_reg.low_power, s_reg.key,
                                  s_reg.mode, s_reg.channel, 3'h0}; // RULE_16
      `RSI_ADDR_IRQ_STAT: rd_mux = {12'h000, s_reg.irq_stat};
      `RSI_ADDR_IRQ_MASK: rd_mux = {12'h000, s_reg.irq_mask};
      `RSI_ADDR_SELECT: rd_mux = {7'h00, rem.channel_select_line, rem.mode_select,
                                  rem.fsk_bit_four_or_clock, rem.fsk_bit_two, rem.fsk_bit_one,
                                  rem.key}; // RULE_10
      `RSI_ADDR_AUDIO: rd_mux = s_reg.audio_hold;
      `RSI_ADDR_ALARM: rd_mux = {10'h000, s_reg.alarm};
      `RSI_ADDR_CTRL: rd_mux = {15'h0000, s_reg.modulating};
      default: rd_mux = `RSI_ZERO16;
    endcase
  end

  assign div_max = 2'(`RSI_SCLK_DIV - 1);

  always_comb begin
    s_next = s_reg;
    irq_set = '0;
    s_next.channel = ch_dec;
    if (mode_valid) begin
      s_next.mode = mode_dec;
    end
    s_next.key = rem.key; // RULE_15
    s_next.low_power = rem.low_power_mode; // RULE_16
    // only bits one and two are forwarded; the upper two bits stay zero
    s_next.fsk = (s_reg.mode == RSI_MODE_ANALOG) ? 4'h0 :
                 {2'b00, rem.fsk_bit_two, rem.fsk_bit_one}; // RULE_06
    irq_set[`RSI_IRQ_CHAN] = (ch_dec != s_reg.channel);
    irq_set[`RSI_IRQ_MODE] = mode_valid && (mode_dec != s_reg.mode);
    irq_set[`RSI_IRQ_KEY] = (rem.key != s_reg.key);
    irq_set[`RSI_IRQ_LOWPWR] = (rem.low_power_mode != s_reg.low_power);
    s_next.rdata = rd_in ? rd_mux : `RSI_ZERO16;
    s_next.dac.wr_a = 1'b0;
    s_next.dac.wr_b = 1'b0;
    if (wr_in) begin
      case (addr_in)
        `RSI_ADDR_CTRL: s_next.modulating = wdata_in[0]; // RULE_14
        `RSI_ADDR_IRQ_STAT: s_next.irq_stat = s_reg.irq_stat & ~wdata_in[`RSI_IRQ_BITS-1:0];
        `RSI_ADDR_IRQ_MASK: s_next.irq_mask = wdata_in[`RSI_IRQ_BITS-1:0];
        `RSI_ADDR_FWD: begin
          s_next.dac.wr_a = 1'b1; // RULE_09
          s_next.dac.data = wdata_in;
        end
        `RSI_ADDR_REF: begin
          s_next.dac.wr_b = 1'b1; // RULE_09
          s_next.dac.data = wdata_in;
        end
        `RSI_ADDR_AUDIO: s_next.audio_hold = wdata_in;
        `RSI_ADDR_ALARM: s_next.alarm = wdata_in[$bits(rsi_alarm_t)-1:0]; // RULE_11 RULE_12 RULE_13
        default: ;
      endcase
    end
    // set wins over clear
    s_next.irq_stat = s_next.irq_stat | irq_set;
    // serial link clocked at 6.25 MHz, sclk toggling every two clocks
    if (s_reg.div_cnt == div_max) begin // RULE_08
      s_next.div_cnt = 2'h0;
      s_next.sclk = ~s_reg.sclk;
      if (s_reg.sclk) begin
        s_next.frame = 1'b0;
        if (s_reg.bit_cnt == 5'(`RSI_SAMPLE_BITS - 1)) begin
          s_next.bit_cnt = 5'h00;
          s_next.audio_shift = (s_reg.mode == RSI_MODE_ANALOG) ? s_reg.audio_hold : `RSI_ZERO16; // RULE_07
          s_next.frame = 1'b1;
        end else begin
          s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
          s_next.audio_shift = {s_reg.audio_shift[14:0], 1'b0};
        end
        s_next.sdata = s_next.audio_shift[15]; // RULE_07
      end
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_out = s_reg.rdata;
  assign irq_out = |(s_reg.irq_stat & s_reg.irq_mask);
  assign alarm_out = s_reg.alarm; // RULE_12 RULE_13
  assign modulating_indicator_out = s_reg.modulating; // RULE_14
  assign fsk_data_out = s_reg.fsk; // RULE_06
  assign mode_out = s_reg.mode;
  assign channel_out = s_reg.channel;
  assign key_out = s_reg.key;
  assign link_out = '{sclk: s_reg.sclk, frame: s_reg.frame, sdata: s_reg.sdata};
  assign dac_out = s_reg.dac;
endmodule // rsi_top
`default_nettype wire
